// ===== hw/flash_seq_pkg.sv
// Constants and types for the flash page-program sequencer
package flash_seq_pkg;

  // ==========================================================================
  // Key bytes written to the flash control register
  localparam logic [7:0]  KEY_USER_FIRST  = 8'h50;
  localparam logic [7:0]  KEY_USER_SECOND = 8'ha0;
  localparam logic [7:0]  KEY_XROW_FIRST  = 8'h52;
  localparam logic [7:0]  KEY_XROW_SECOND = 8'ha2;
  localparam logic [7:0]  FCR_RESET       = 8'h00;

  // ==========================================================================
  // Column latch address windows
  localparam logic [15:0] USER_ADDR_LO    = 16'h0000;
  localparam logic [15:0] USER_ADDR_HI    = 16'h3fff;
  localparam logic [15:0] XROW_ADDR_LO    = 16'hff80;
  localparam logic [15:0] XROW_ADDR_HI    = 16'hffff;

  // ==========================================================================
  // Page geometry: one page is the size of the extra row
  localparam int          PAGE_BYTES      = 128;
  localparam int          IDX_W           = 7;
  localparam int          PAGE_W          = 9;
  localparam logic [6:0]  IDX_LAST        = 7'h7f;

  // ==========================================================================
  // Sequencer states
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_STREAM,
    SEQ_COMMIT,
    SEQ_WAIT
  } seq_state_e;

  // Latch load request from the CPU
  typedef struct packed {
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  data;
  } latch_req_s;

  // Byte handed to the flash array
  typedef struct packed {
    logic        wr;
    logic        extra_row;
    logic [15:0] addr;
    logic [7:0]  data;
  } array_wr_s;

  // Whole state of the sequencer
  typedef struct packed {
    seq_state_e              fsm;
    logic [7:0]              fcr;
    logic                    arm_user;
    logic                    arm_xrow;
    logic                    busy;
    logic                    xrow;
    logic [PAGE_W-1:0]       page;
    logic [IDX_W-1:0]        idx;
    logic [PAGE_BYTES-1:0]   vld;
    logic [PAGE_BYTES*8-1:0] data;
    array_wr_s               aw;
    logic                    commit;
  } seq_state_s;

  localparam seq_state_s SEQ_RESET = '0;

endpackage : flash_seq_pkg

// ===== hw/flash_page_program_sequencer.sv
// Flash page-program sequencer: column latches, key decode, busy flag
`timescale 1ns/1ps
`default_nettype none

module flash_page_program_sequencer (
  // Clock, reset, enable
  input  wire logic                      sys_clk,
  input  wire logic                      sys_rst,
  input  wire logic                      clk_en,
  // Column latch loads from the CPU
  input  wire flash_seq_pkg::latch_req_s latch_req,
  // Flash control register write port
  input  wire logic                      fcr_wr,
  input  wire logic [7:0]                fcr_wdata,
  // Flash control register and busy read-back
  output logic [7:0]                     flash_control_reg,
  output logic                           flash_busy_flag,
  // Flash array side
  output flash_seq_pkg::array_wr_s       array_wr,
  input  wire logic                      array_ack,
  output logic                           array_commit,
  input  wire logic                      array_done
);

  // ==========================================================================
  // State
  flash_seq_pkg::seq_state_s st_ff;
  flash_seq_pkg::seq_state_s nxt_st;

  logic in_user;
  logic in_xrow;
  logic aw_hold;

  assign in_user = (latch_req.addr >= flash_seq_pkg::USER_ADDR_LO) &&
                   (latch_req.addr <= flash_seq_pkg::USER_ADDR_HI);
  assign in_xrow = (latch_req.addr >= flash_seq_pkg::XROW_ADDR_LO) &&
                   (latch_req.addr <= flash_seq_pkg::XROW_ADDR_HI);
  assign aw_hold = st_ff.aw.wr && !array_ack;

  // ==========================================================================
  // Next state
  always_comb
  begin
    nxt_st = st_ff;
    // Latch loads only while idle
    if (latch_req.wr && !st_ff.busy && (in_user || in_xrow))
    begin
      nxt_st.vld[latch_req.addr[flash_seq_pkg::IDX_W-1:0]] = 1'b1;
      nxt_st.data[latch_req.addr[flash_seq_pkg::IDX_W-1:0]*8 +: 8] = latch_req.data;
      nxt_st.page = latch_req.addr[15:flash_seq_pkg::IDX_W];
    end
    // Key decode; every write breaks a pending first key
    if (fcr_wr)
    begin
      nxt_st.fcr      = fcr_wdata;
      nxt_st.arm_user = 1'b0;
      nxt_st.arm_xrow = 1'b0;
      if (!st_ff.busy)
      begin
        if (st_ff.arm_user && fcr_wdata == flash_seq_pkg::KEY_USER_SECOND)
        begin
          nxt_st.busy = 1'b1;
          nxt_st.xrow = 1'b0;
          nxt_st.idx  = '0;
          nxt_st.fsm  = flash_seq_pkg::SEQ_STREAM;
        end
        else if (st_ff.arm_xrow && fcr_wdata == flash_seq_pkg::KEY_XROW_SECOND)
        begin
          nxt_st.busy = 1'b1;
          nxt_st.xrow = 1'b1;
          nxt_st.idx  = '0;
          nxt_st.fsm  = flash_seq_pkg::SEQ_STREAM;
        end
        else
        begin
          nxt_st.arm_user = (fcr_wdata == flash_seq_pkg::KEY_USER_FIRST);
          nxt_st.arm_xrow = (fcr_wdata == flash_seq_pkg::KEY_XROW_FIRST);
        end
      end
    end
    // Programming sequence
    unique case (st_ff.fsm)
      flash_seq_pkg::SEQ_IDLE:
      begin
        nxt_st.aw.wr  = 1'b0;
        nxt_st.commit = 1'b0;
      end
      flash_seq_pkg::SEQ_STREAM:
      begin
        if (!aw_hold)
        begin
          nxt_st.aw.wr        = st_ff.vld[st_ff.idx];
          nxt_st.aw.extra_row = st_ff.xrow;
          nxt_st.aw.data      = st_ff.data[st_ff.idx*8 +: 8];
          if (st_ff.xrow)
            nxt_st.aw.addr = flash_seq_pkg::XROW_ADDR_LO | {9'h000, st_ff.idx};
          else
            nxt_st.aw.addr = {st_ff.page, st_ff.idx};
          nxt_st.idx = st_ff.idx + 7'h01;
          if (st_ff.idx == flash_seq_pkg::IDX_LAST)
            nxt_st.fsm = flash_seq_pkg::SEQ_COMMIT;
        end
      end
      flash_seq_pkg::SEQ_COMMIT:
      begin
        if (!aw_hold)
        begin
          nxt_st.aw.wr  = 1'b0;
          nxt_st.commit = 1'b1;
          nxt_st.fsm    = flash_seq_pkg::SEQ_WAIT;
        end
      end
      flash_seq_pkg::SEQ_WAIT:
      begin
        nxt_st.commit = 1'b0;
        if (array_done)
        begin
          nxt_st.busy = 1'b0;
          nxt_st.vld  = '0;
          nxt_st.fsm  = flash_seq_pkg::SEQ_IDLE;
        end
      end
    endcase
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      st_ff <= flash_seq_pkg::SEQ_RESET;
    else if (clk_en)
      st_ff <= nxt_st;
  end

  assign flash_control_reg = st_ff.fcr;
  assign flash_busy_flag   = st_ff.busy;
  assign array_wr          = st_ff.aw;
  assign array_commit      = st_ff.commit;

  // ==========================================================================
  // Checks
  user_launch_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (clk_en && fcr_wr && fcr_wdata == flash_seq_pkg::KEY_USER_SECOND && st_ff.arm_user && !st_ff.busy)
    |=> (flash_busy_flag && !st_ff.xrow))
    else $error("user key pair did not launch");

  xrow_launch_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (clk_en && fcr_wr && fcr_wdata == flash_seq_pkg::KEY_XROW_SECOND && st_ff.arm_xrow && !st_ff.busy)
    |=> (flash_busy_flag && st_ff.xrow))
    else $error("extra-row key pair did not launch");

  stray_key_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (clk_en && fcr_wr && !st_ff.arm_user && !st_ff.arm_xrow && !flash_busy_flag)
    |=> !flash_busy_flag)
    else $error("busy set without a first key");

  busy_rise_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(flash_busy_flag) |-> ($past(fcr_wr) && $past(clk_en) &&
      ($past(st_ff.arm_user) || $past(st_ff.arm_xrow))))
    else $error("busy rose without a key write");

  busy_fall_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $fell(flash_busy_flag) |-> ($past(array_done) && $past(st_ff.fsm) == flash_seq_pkg::SEQ_WAIT))
    else $error("busy fell before array completion");

  busy_held_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (st_ff.fsm != flash_seq_pkg::SEQ_IDLE) |-> flash_busy_flag)
    else $error("busy low while programming");

  page_track_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (clk_en && latch_req.wr && in_user && !flash_busy_flag)
    |=> st_ff.page == $past(latch_req.addr[15:7]))
    else $error("page not taken from last latch address");

  xrow_addr_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (array_wr.wr && st_ff.xrow) |-> (array_wr.extra_row && array_wr.addr >= flash_seq_pkg::XROW_ADDR_LO))
    else $error("extra-row byte sent to wrong space");

  user_addr_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (array_wr.wr && !array_wr.extra_row) |-> array_wr.addr <= flash_seq_pkg::USER_ADDR_HI)
    else $error("user byte outside user array");

  user_prog_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
    $fell(flash_busy_flag) && !st_ff.xrow);
  xrow_prog_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
    $fell(flash_busy_flag) && st_ff.xrow);
  broken_key_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
    st_ff.arm_user && fcr_wr && fcr_wdata != flash_seq_pkg::KEY_USER_SECOND);

endmodule : flash_page_program_sequencer

`default_nettype wire

// ===== test/flash_array_model.sv
// Flash array model: takes streamed bytes, captures the page, answers commit with done
`timescale 1ns/1ps
`default_nettype none
module flash_array_model (
  // Clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     sys_rst,
  // Sequencer side
  input  wire flash_seq_pkg::array_wr_s array_wr,
  input  wire logic                     array_commit,
  output logic                          array_ack,
  output logic                          array_done,
  // Test control: ack only every other cycle
  input  wire logic                     slow
);
  // ==========================================================================
  // Captured page
  logic [7:0] mem [128];
  logic [8:0] pg;
  logic       xr;
  logic [7:0] cnt;
  logic [7:0] ncap;
  logic [2:0] dly;
  logic       tgl;

  assign array_ack = array_wr.wr && (!slow || tgl);

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      {cnt, ncap, dly, tgl, array_done} <= '0;
    end
    else
    begin
      tgl        <= !tgl;
      array_done <= (dly == 3'h1);
      if (dly != 3'h0)
        dly <= dly - 3'h1;
      if (array_commit)
      begin
        ncap <= cnt;
        cnt  <= 8'h00;
        dly  <= 3'h4;
      end
      if (array_ack)
      begin
        mem[array_wr.addr[6:0]] <= array_wr.data;
        pg  <= array_wr.addr[15:7];
        xr  <= array_wr.extra_row;
        cnt <= cnt + 8'h01;
      end
    end
  end
endmodule : flash_array_model
`default_nettype wire

// ===== test/tb.sv
// Testbench for the flash page-program sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                      sys_clk   = 1'b0;
  logic                      sys_rst   = 1'b1;
  logic                      clk_en    = 1'b1;
  logic                      fcr_wr    = 1'b0;
  logic                      slow      = 1'b0;
  logic [7:0]                fcr_wdata = 8'h00;
  flash_seq_pkg::latch_req_s latch_req = '0;
  flash_seq_pkg::array_wr_s  array_wr;
  logic [7:0]                flash_control_reg;
  logic                      flash_busy_flag, array_ack, array_commit, array_done;
  int                        miscompares = 0;
  int                        check_count = 0;

  always #2.5 sys_clk = ~sys_clk;

  flash_page_program_sequencer dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .latch_req(latch_req), .fcr_wr(fcr_wr), .fcr_wdata(fcr_wdata), .flash_control_reg(flash_control_reg),
    .flash_busy_flag(flash_busy_flag), .array_wr(array_wr), .array_ack(array_ack),
    .array_commit(array_commit), .array_done(array_done));
  flash_array_model arr (.sys_clk(sys_clk), .sys_rst(sys_rst), .array_wr(array_wr),
    .array_commit(array_commit), .array_ack(array_ack), .array_done(array_done), .slow(slow));

  // ==========================================================================
  // Shared tasks
  task test_done;
    if (miscompares == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done

  task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task ld(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk) latch_req <= '{1'b1, a, d};
    @(posedge sys_clk) latch_req <= '0;
  endtask : ld

  task wk(input logic [7:0] b);
    @(posedge sys_clk);
    fcr_wr    <= 1'b1;
    fcr_wdata <= b;
    @(posedge sys_clk) fcr_wr <= 1'b0;
  endtask : wk

  // Key pair, busy check, wait for the end, then write 00 to the control register
  task key_pair(input logic [7:0] k1, input logic [7:0] k2, input logic start);
    // Keys back to back, as from boot flash code with interrupts off
    wk(k1);
    wk(k2);
    #1 chk("busy_on_key", flash_busy_flag, start);
    chk("fcr_readback", flash_control_reg, k2);
    if (start)
    begin
      repeat (50) @(posedge sys_clk);
      #1 chk("busy_hold", flash_busy_flag, 1'b1);
      for (int i = 0; i < 2000 && flash_busy_flag !== 1'b0; i++)
        @(negedge sys_clk);
      chk("busy_clear", flash_busy_flag, 1'b0);
    end
    wk(8'h00);
  endtask : key_pair

  // ==========================================================================
  // Scenarios
  task test_user;
    slow <= 1'b1;
    ld(16'h3fff, 8'h77);
    ld(16'h0105, 8'ha5);
    ld(16'h8001, 8'h5a);
    ld(16'h0383, 8'h3c);
    key_pair(8'h50, 8'ha0, 1'b1);
    chk("user_idx7f", arr.mem[127], 8'h77);
    chk("user_idx5", arr.mem[5], 8'ha5);
    chk("user_idx3", arr.mem[3], 8'h3c);
    chk("user_page", arr.pg, 9'h007);
    chk("user_xrow", arr.xr, 1'b0);
    chk("user_count", arr.ncap, 8'h03);
  endtask : test_user

  task test_xrow;
    slow <= 1'b0;
    ld(16'hff80, 8'h11);
    ld(16'hffff, 8'hee);
    key_pair(8'h52, 8'ha2, 1'b1);
    chk("xrow_idx0", arr.mem[0], 8'h11);
    chk("xrow_idx7f", arr.mem[127], 8'hee);
    chk("xrow_target", arr.xr, 1'b1);
    chk("xrow_addr", arr.pg, 9'h1ff);
    chk("xrow_count", arr.ncap, 8'h02);
  endtask : test_xrow

  task test_bad_keys;
    key_pair(8'h50, 8'ha2, 1'b0);
    key_pair(8'h52, 8'ha0, 1'b0);
    wk(8'h50);
    key_pair(8'h00, 8'ha0, 1'b0);
    key_pair(8'ha2, 8'ha2, 1'b0);
  endtask : test_bad_keys

  // Clock enable low: key writes must leave no trace
  task test_freeze;
    clk_en <= 1'b0;
    wk(8'h50);
    wk(8'ha0);
    #1 chk("frozen_busy", flash_busy_flag, 1'b0);
    chk("frozen_fcr", flash_control_reg, 8'h00);
    @(posedge sys_clk) clk_en <= 1'b1;
    wk(8'ha0);
    #1 chk("thawed_busy", flash_busy_flag, 1'b0);
    chk("thawed_fcr", flash_control_reg, 8'ha0);
    wk(8'h00);
  endtask : test_freeze

  initial
  begin
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    #1 chk("reset_busy", flash_busy_flag, 1'b0);
    chk("reset_fcr", flash_control_reg, 8'h00);
    test_user();
    test_xrow();
    test_bad_keys();
    test_freeze();
    test_done();
  end

  initial
  begin
    #50us;
    miscompares++;
    test_done();
  end
endmodule : tb
`default_nettype wire
